// >>> hdl/rtc_pkg.sv
// Constants for the time, calendar and flag block of the real-time clock.
// Assumes a 250 MHz system clock and a 32.768 kHz crystal level on an input.
//
// Behaviour
// - Crystal clock drives the output pin unless both disable bits are set.
// - Periodic flag reads 1 while the periodic interrupt holds pin A low.
// - Level mode: write 0 to periodic flag releases pin A; 1 ignored.
// - Alarm flag sets about 61 us after a match, only while enabled.
// - Writing 0 clears an alarm flag and releases its pin; 1 ignored.
// - Alarm flag reads 0 while its enable bit is 0.
// - Seconds count BCD 00 to 59, wrap carries into minutes.
// - Minutes count BCD 00 to 59, wrap carries into hours.
// - Hours give day carry at 23 to 00, or PM 11 to AM 12.
// - Any write to seconds clears the sub-second divider.
// - Weekday counts 0 to 6 on each day carry, then back to 0.
// - Day of month runs 1 to 31, 30 or 28; February 29 in leap years.
// - Month end returns day to 1 and steps month; month 12 steps year.
// - Year counts BCD 00 to 99; multiples of four leap; wrap to century.
// - Century bit toggles on every year wrap from 99 to 00.
// - Time at 0 to 2, weekday 3, calendar 4 to 6; unused bits read 0.
// - Century bit sits at bit 7 of month register, month in bits 4 to 0.
// - Level mode fires once per second, minute, hour or month on tick.
// - Reset clears control and flag bits, interrupt pins inactive.

package rtc_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [3:0] ADDR_SEC = 4'h0;
    localparam logic [3:0] ADDR_MIN = 4'h1;
    localparam logic [3:0] ADDR_HOUR = 4'h2;
    localparam logic [3:0] ADDR_WDAY = 4'h3;
    localparam logic [3:0] ADDR_MDAY = 4'h4;
    localparam logic [3:0] ADDR_MON = 4'h5;
    localparam logic [3:0] ADDR_YEAR = 4'h6;
    localparam logic [3:0] ADDR_CTRL1 = 4'he;
    localparam logic [3:0] ADDR_CTRL2 = 4'hf;

    // ==========================================================
    // Field positions
    localparam int CR1_WEEK_EN = 7;
    localparam int CR1_DAY_EN = 6;
    localparam int CR1_MODE24 = 5;
    localparam int CR1_CLKDIS_B = 4;
    localparam int CR1_TEST = 3;
    localparam int CR2_CLKDIS_A = 3;
    localparam int CR2_PERIODIC_IRQ_FLAG = 2;
    localparam int CR2_WEEK_FLAG = 1;
    localparam int CR2_DAY_FLAG = 0;
    localparam int MON_CENTURY = 7;
    localparam int HOUR_PM = 5;

    // ==========================================================
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] TIME_RST = 8'h00;
    localparam logic [7:0] DATE_RST = 8'h01;
    localparam logic [2:0] WDAY_RST = 3'h0;

    // ==========================================================
    // Counting limits
    localparam logic [14:0] DIV_LAST = 15'h7fff;
    localparam logic [7:0] BCD_59 = 8'h59;
    localparam logic [7:0] BCD_23 = 8'h23;
    localparam logic [7:0] BCD_12 = 8'h12;
    localparam logic [7:0] BCD_11 = 8'h11;
    localparam logic [7:0] BCD_99 = 8'h99;
    localparam logic [2:0] WDAY_LAST = 3'h6;

    // ==========================================================
    // Alarm flag delay
    localparam int CLK_PERIOD_PS = 4000;
    localparam int ALARM_DELAY_PS = 61000000;
    localparam int ALARM_DELAY_CYC = ALARM_DELAY_PS / CLK_PERIOD_PS;

    // ==========================================================
    // Periodic interrupt select codes
    typedef enum logic [2:0] {
        CT_OFF = 3'b000,
        CT_LOW = 3'b001,
        CT_2HZ = 3'b010,
        CT_1HZ = 3'b011,
        CT_SEC = 3'b100,
        CT_MIN = 3'b101,
        CT_HOUR = 3'b110,
        CT_MONTH = 3'b111
    } rtc_ct_e;

endpackage

// >>> hdl/rtc_time_calendar.sv
// Time and calendar counters, clock output and interrupt flags of the RTC.
// Assumes the crystal level and register port are synchronous to mclk.
`timescale 1ns/100ps

module rtc_time_calendar #(
    parameter int ALARM_DELAY_CYCLES = rtc_pkg::ALARM_DELAY_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Crystal level
    input wire logic xtal_in,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Alarm comparator matches, index 0 day, 1 week
    input wire logic day_alarm_match,
    input wire logic week_alarm_match,
    // Pins
    output logic crystal_clock_out,
    output logic irq_pin_a_n,
    output logic irq_pin_b_n
);

    // ==========================================================
    // Helpers
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction

    // ==========================================================
    // State
    logic xtal_q;
    logic [14:0] div;
    logic [7:0] sec, min, hour, mday, mon, year;
    logic [2:0] wday;
    logic century;
    logic [7:0] ctrl1;
    logic clkdis_a;
    logic periodic_irq_flag;
    logic lvl_pend;
    logic [1:0] al_flag;
    logic [1:0] al_busy;
    logic [15:0] al_cnt [2];

    // ==========================================================
    // Write decode
    wire wr_sec = reg_wr && reg_addr == rtc_pkg::ADDR_SEC;
    wire wr_min = reg_wr && reg_addr == rtc_pkg::ADDR_MIN;
    wire wr_hour = reg_wr && reg_addr == rtc_pkg::ADDR_HOUR;
    wire wr_wday = reg_wr && reg_addr == rtc_pkg::ADDR_WDAY;
    wire wr_mday = reg_wr && reg_addr == rtc_pkg::ADDR_MDAY;
    wire wr_mon = reg_wr && reg_addr == rtc_pkg::ADDR_MON;
    wire wr_year = reg_wr && reg_addr == rtc_pkg::ADDR_YEAR;
    wire wr_ctrl1 = reg_wr && reg_addr == rtc_pkg::ADDR_CTRL1;
    wire wr_ctrl2 = reg_wr && reg_addr == rtc_pkg::ADDR_CTRL2;

    wire mode24 = ctrl1[rtc_pkg::CR1_MODE24];
    wire [2:0] ct_sel = ctrl1[2:0];
    wire [1:0] al_en = {ctrl1[rtc_pkg::CR1_WEEK_EN],
                        ctrl1[rtc_pkg::CR1_DAY_EN]};
    wire [1:0] al_match = {week_alarm_match, day_alarm_match};
    wire [1:0] al_clr = {wr_ctrl2 && !reg_wdata[rtc_pkg::CR2_WEEK_FLAG],
                         wr_ctrl2 && !reg_wdata[rtc_pkg::CR2_DAY_FLAG]};

    // ==========================================================
    // Carry chain
    wire xtal_rise = xtal_in && !xtal_q;
    wire sec_tick = xtal_rise && div == rtc_pkg::DIV_LAST;
    wire sec_wrap = sec == rtc_pkg::BCD_59;
    wire [7:0] next_sec = sec_wrap ? rtc_pkg::TIME_RST : bcd_inc(sec);
    wire min_step = sec_tick && sec_wrap;
    wire min_wrap = min == rtc_pkg::BCD_59;
    wire [7:0] next_min = min_wrap ? rtc_pkg::TIME_RST : bcd_inc(min);
    wire hour_step = min_step && min_wrap;

    // Bit 5 is PM or tens-of-twenty
    wire pm = hour[rtc_pkg::HOUR_PM];
    wire [7:0] hour12 = {3'h0, hour[4:0]};
    wire [7:0] hour12_inc = bcd_inc(hour12);
    wire [7:0] next_hour12 =
        (hour12 == rtc_pkg::BCD_12) ? {2'h0, pm, 5'h01} :
        (hour12 == rtc_pkg::BCD_11) ? {2'h0, !pm, 5'h12} :
        {2'h0, pm, hour12_inc[4:0]};
    wire [7:0] next_hour24 = (hour == rtc_pkg::BCD_23) ?
        rtc_pkg::TIME_RST : bcd_inc(hour);
    wire hour_wrap = mode24 ? hour == rtc_pkg::BCD_23 :
        (pm && hour12 == rtc_pkg::BCD_11);
    wire [7:0] next_hour = mode24 ? next_hour24 : next_hour12;
    wire day_step = hour_step && hour_wrap;

    wire [2:0] next_wday = (wday == rtc_pkg::WDAY_LAST) ?
        rtc_pkg::WDAY_RST : wday + 3'h1;

    // Leap when BCD year divisible by four
    wire [3:0] yu = year[3:0];
    wire leap = (!year[4] && (yu == 4'h0 || yu == 4'h4 || yu == 4'h8)) ||
                (year[4] && (yu == 4'h2 || yu == 4'h6));
    wire short_mon = mon == 8'h04 || mon == 8'h06 || mon == 8'h09 ||
                     mon == 8'h11;
    wire [7:0] last_day = (mon == 8'h02) ? (leap ? 8'h29 : 8'h28) :
                          short_mon ? 8'h30 : 8'h31;
    // Day returns to 1, month 12 returns to 1
    wire mday_wrap = mday == last_day;
    wire [7:0] next_mday = mday_wrap ? rtc_pkg::DATE_RST : bcd_inc(mday);
    wire month_step = day_step && mday_wrap;
    wire mon_wrap = mon == rtc_pkg::BCD_12;
    wire [7:0] next_mon = mon_wrap ? rtc_pkg::DATE_RST : bcd_inc(mon);
    wire year_step = month_step && mon_wrap;
    wire year_wrap = year == rtc_pkg::BCD_99;
    wire [7:0] next_year = year_wrap ? rtc_pkg::TIME_RST : bcd_inc(year);

    // ==========================================================
    // Periodic interrupt
    // Level event on the second tick
    wire lvl_event = sec_tick && (
        ct_sel == rtc_pkg::CT_SEC ||
        (ct_sel == rtc_pkg::CT_MIN && sec_wrap) ||
        (ct_sel == rtc_pkg::CT_HOUR && hour_step) ||
        (ct_sel == rtc_pkg::CT_MONTH && month_step));
    // Write 0 releases; event in same cycle wins
    wire periodic_irq_flag_clr = wr_ctrl2 && !reg_wdata[rtc_pkg::CR2_PERIODIC_IRQ_FLAG];
    wire next_lvl_pend = ct_sel[2] &&
        (lvl_event || (lvl_pend && !periodic_irq_flag_clr));
    // Pulse modes follow the divider, so they restart on a seconds write
    wire next_periodic_irq_flag = (ct_sel == rtc_pkg::CT_LOW) ||
        (ct_sel == rtc_pkg::CT_2HZ && !div[13]) ||
        (ct_sel == rtc_pkg::CT_1HZ && !div[14]) ||
        next_lvl_pend;

    // ==========================================================
    // Alarm flags
    logic [1:0] al_set;
    logic [1:0] next_al_flag;
    for (genvar i = 0; i < 2; i++) begin : g_alarm
        // Flag set after the match delay
        assign al_set[i] = al_busy[i] &&
            al_cnt[i] == 16'(ALARM_DELAY_CYCLES - 1);
        // Write 0 clears, set wins; disabled reads 0
        assign next_al_flag[i] = al_en[i] &&
            (al_set[i] || (al_flag[i] && !al_clr[i]));

        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                al_busy[i] <= 1'b0;
                al_cnt[i] <= 16'h0000;
            end else if (!al_en[i] || al_set[i]) begin
                al_busy[i] <= 1'b0;
                al_cnt[i] <= 16'h0000;
            end else if (al_busy[i]) begin
                al_cnt[i] <= al_cnt[i] + 16'h0001;
            end else if (al_match[i]) begin
                al_busy[i] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Read mux
    logic [7:0] rd_mux;
    // Map and zero upper bits; century at bit 7
    wire [7:0] rd_sec = {1'b0, sec[6:0]};
    wire [7:0] rd_min = {1'b0, min[6:0]};
    wire [7:0] rd_hour = {2'h0, hour[5:0]};
    wire [7:0] rd_wday = {5'h00, wday};
    wire [7:0] rd_mday = {2'h0, mday[5:0]};
    wire [7:0] rd_mon = {century, 2'h0, mon[4:0]};
    wire [7:0] rd_ctrl2 = {4'h0, clkdis_a, periodic_irq_flag, al_flag};
    assign rd_mux =
        (reg_addr == rtc_pkg::ADDR_SEC) ? rd_sec :
        (reg_addr == rtc_pkg::ADDR_MIN) ? rd_min :
        (reg_addr == rtc_pkg::ADDR_HOUR) ? rd_hour :
        (reg_addr == rtc_pkg::ADDR_WDAY) ? rd_wday :
        (reg_addr == rtc_pkg::ADDR_MDAY) ? rd_mday :
        (reg_addr == rtc_pkg::ADDR_MON) ? rd_mon :
        (reg_addr == rtc_pkg::ADDR_YEAR) ? year :
        (reg_addr == rtc_pkg::ADDR_CTRL1) ? ctrl1 :
        (reg_addr == rtc_pkg::ADDR_CTRL2) ? rd_ctrl2 : 8'h00;

    // ==========================================================
    // Divider and pins
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            xtal_q <= 1'b0;
        end else begin
            xtal_q <= xtal_in;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div <= 15'h0000;
        end else if (wr_sec) begin
            div <= 15'h0000;
        end else if (xtal_rise) begin
            div <= div + 15'h0001;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            crystal_clock_out <= 1'b0;
            irq_pin_a_n <= 1'b1;
            irq_pin_b_n <= 1'b1;
            reg_rdata <= 8'h00;
        end else begin
            // Forced low only when both disables set, else follows crystal
            crystal_clock_out <= xtal_in &&
                !(clkdis_a && ctrl1[rtc_pkg::CR1_CLKDIS_B]);
            // Pin A tracks periodic flag and day alarm flag
            irq_pin_a_n <= !(next_periodic_irq_flag || next_al_flag[0]);
            irq_pin_b_n <= !next_al_flag[1];
            reg_rdata <= rd_mux;
        end
    end

    // ==========================================================
    // Control and flags
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl1 <= rtc_pkg::CTRL_RST;
            clkdis_a <= 1'b0;
        end else begin
            if (wr_ctrl1) begin
                ctrl1 <= reg_wdata & ~(8'h01 << rtc_pkg::CR1_TEST);
            end
            if (wr_ctrl2) begin
                clkdis_a <= reg_wdata[rtc_pkg::CR2_CLKDIS_A];
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            periodic_irq_flag <= 1'b0;
            lvl_pend <= 1'b0;
            al_flag <= 2'h0;
        end else begin
            // Flag mirrors the periodic pin level
            periodic_irq_flag <= next_periodic_irq_flag;
            lvl_pend <= next_lvl_pend;
            al_flag <= next_al_flag;
        end
    end

    // ==========================================================
    // Time and calendar counters
    // Host write wins over a carry landing in the same cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sec <= rtc_pkg::TIME_RST;
        end else if (wr_sec) begin
            sec <= {1'b0, reg_wdata[6:0]};
        end else if (sec_tick) begin
            sec <= next_sec;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            min <= rtc_pkg::TIME_RST;
        end else if (wr_min) begin
            min <= {1'b0, reg_wdata[6:0]};
        end else if (min_step) begin
            min <= next_min;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hour <= rtc_pkg::TIME_RST;
        end else if (wr_hour) begin
            hour <= {2'h0, reg_wdata[5:0]};
        end else if (hour_step) begin
            hour <= next_hour;
        end
    end

    // A written 7 is kept and stepped as any other code
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wday <= rtc_pkg::WDAY_RST;
        end else if (wr_wday) begin
            wday <= reg_wdata[2:0];
        end else if (day_step) begin
            wday <= next_wday;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mday <= rtc_pkg::DATE_RST;
        end else if (wr_mday) begin
            mday <= {2'h0, reg_wdata[5:0]};
        end else if (day_step) begin
            mday <= next_mday;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mon <= rtc_pkg::DATE_RST;
        end else if (wr_mon) begin
            mon <= {3'h0, reg_wdata[4:0]};
        end else if (month_step) begin
            mon <= next_mon;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            year <= rtc_pkg::TIME_RST;
        end else if (wr_year) begin
            year <= reg_wdata;
        end else if (year_step) begin
            year <= next_year;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            century <= 1'b0;
        end else if (wr_mon) begin
            century <= reg_wdata[rtc_pkg::MON_CENTURY];
        end else if (year_step && year_wrap) begin
            century <= !century;
        end
    end

endmodule // rtc_time_calendar

// >>> testbench/rtc_tc_asserts.sv
// Port checker for the time, calendar and flag block.
// Assumes binding to rtc_time_calendar; sees its ports only.
`timescale 1ns/100ps

module rtc_tc_asserts #(
    parameter int ALARM_DELAY_CYCLES = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Inputs
    input wire logic xtal_in,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic week_alarm_match,
    // Outputs
    input wire logic [7:0] reg_rdata,
    input wire logic crystal_clock_out,
    input wire logic irq_pin_a_n,
    input wire logic irq_pin_b_n
);
    // ========
    // Shadow of control bits, seen from writes
    logic dis_a, dis_b, wk_en, c1_wr, c2_wr;
    logic [2:0] ct_sel;
    int wk_cnt;
    assign c1_wr = reg_wr && reg_addr == rtc_pkg::ADDR_CTRL1;
    assign c2_wr = reg_wr && reg_addr == rtc_pkg::ADDR_CTRL2;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {wk_en, dis_b, ct_sel, dis_a} <= '0;
        end else begin
            if (c1_wr) {wk_en, dis_b} <= {reg_wdata[7], reg_wdata[4]};
            if (c1_wr) ct_sel <= reg_wdata[2:0];
            if (c2_wr) dis_a <= reg_wdata[3];
        end
    end
    // Matches while busy are ignored, as in the device
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) wk_cnt <= 0;
        else if (!wk_en || wk_cnt == ALARM_DELAY_CYCLES) wk_cnt <= 0;
        else if (wk_cnt != 0 || week_alarm_match) wk_cnt <= wk_cnt + 1;
    end

    // ========
    // Properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    AST_CLK_OFF: assert property (dis_a && dis_b |=> !crystal_clock_out)
        else $error("clock output not low while disabled");
    AST_CLK_ON: assert property (!(dis_a && dis_b)
        |=> crystal_clock_out == $past(xtal_in))
        else $error("clock output not following crystal");
    AST_RESET_OUT: assert property ($rose(resetn)
        |-> irq_pin_a_n && irq_pin_b_n && reg_rdata == 8'h00)
        else $error("outputs not idle after reset");
    AST_UNMAPPED: assert property (reg_addr inside {[4'h7:4'hd]}
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_WDAY_BITS: assert property (reg_addr == rtc_pkg::ADDR_WDAY
        |=> reg_rdata[7:3] == 5'h00)
        else $error("weekday upper bits set");
    AST_SEC_RANGE: assert property (reg_addr == rtc_pkg::ADDR_SEC
        |=> reg_rdata <= 8'h59)
        else $error("seconds out of range");
    AST_MON_BITS: assert property (reg_addr == rtc_pkg::ADDR_MON
        |=> reg_rdata[6:5] == 2'b00)
        else $error("month unused bits set");
    AST_CT_LOW: assert property (ct_sel == rtc_pkg::CT_LOW
        |=> !irq_pin_a_n)
        else $error("fixed low periodic output not low");
    AST_WEEK_SET: assert property (wk_cnt == ALARM_DELAY_CYCLES
        |=> !irq_pin_b_n)
        else $error("week alarm pin late or missing");
    AST_WEEK_CLEAR: assert property (c2_wr && !reg_wdata[1]
        && wk_cnt != ALARM_DELAY_CYCLES |=> irq_pin_b_n)
        else $error("week alarm pin not released");
    AST_WEEK_OFF: assert property (!wk_en [*2] |=> irq_pin_b_n)
        else $error("week alarm pin low while disabled");
endmodule // rtc_tc_asserts

bind rtc_time_calendar rtc_tc_asserts #(
    .ALARM_DELAY_CYCLES(ALARM_DELAY_CYCLES)
) u_rtc_tc_asserts (
    .mclk(mclk),
    .resetn(resetn),
    .xtal_in(xtal_in),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .week_alarm_match(week_alarm_match),
    .reg_rdata(reg_rdata),
    .crystal_clock_out(crystal_clock_out),
    .irq_pin_a_n(irq_pin_a_n),
    .irq_pin_b_n(irq_pin_b_n)
);

// >>> testbench/rtc_host_model.sv
// Host model on the parallel register port of the block.
// Assumes the bench calls its tasks; drives only at rising mclk.
`timescale 1ns/100ps

module rtc_host_model (
    // Clock
    input wire logic mclk,
    // Register port
    output logic [3:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end

    // Released data is inverted so stale values never pass
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        // Let the write edge settle before callers look at pins
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        @(posedge mclk);
        #1 d = reg_rdata;
    endtask
endmodule // rtc_host_model

// >>> testbench/rtc_time_calendar_tb.sv
// Self-checking bench for the time, calendar and flag block.
// Assumes the checker binds itself; crystal runs at half mclk.
`timescale 1ns/100ps

module rtc_time_calendar_tb;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic xtal_in = 1'b0;
    logic day_alarm_match = 1'b0;
    logic week_alarm_match = 1'b0;
    logic [3:0] reg_addr;
    logic reg_wr;
    logic [7:0] reg_wdata, reg_rdata;
    logic crystal_clock_out, irq_pin_a_n, irq_pin_b_n;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    logic [7:0] wv [7] = '{8'h59, 8'h59, 8'h23, 8'h06, 8'h31, 8'h12, 8'h99};
    logic [7:0] ev [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h81, 8'h00};

    // ========
    // Clock, crystal and timeout
    always #2 mclk = ~mclk;
    // Fast crystal keeps one second near 65536 cycles
    always @(posedge mclk) xtal_in <= ~xtal_in;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            miscompares = miscompares + 1;
            stop_test();
        end
    end

    rtc_host_model u_rtc_host_model (
        .mclk(mclk),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata)
    );

    rtc_time_calendar #(
        .ALARM_DELAY_CYCLES(4)
    ) u_rtc_time_calendar (
        .mclk(mclk),
        .resetn(resetn),
        .xtal_in(xtal_in),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .day_alarm_match(day_alarm_match),
        .week_alarm_match(week_alarm_match),
        .crystal_clock_out(crystal_clock_out),
        .irq_pin_a_n(irq_pin_a_n),
        .irq_pin_b_n(irq_pin_b_n)
    );

    // ========
    // Compare helpers
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: pin %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_rtc_host_model.rd(a, d);
        cmp_byte(d, exp);
    endtask

    task automatic pulse_match(input logic week);
        @(posedge mclk);
        if (week) week_alarm_match <= 1'b1;
        else day_alarm_match <= 1'b1;
        @(posedge mclk);
        week_alarm_match <= 1'b0;
        day_alarm_match <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
    endtask

    // ========
    // Scenarios
    task automatic t_reset();
        chk_reg(rtc_pkg::ADDR_CTRL1, 8'h00);
        chk_reg(rtc_pkg::ADDR_CTRL2, 8'h00);
        cmp_pin(irq_pin_a_n & irq_pin_b_n, 1'b1);
        chk_reg(4'h7, 8'h00);
    endtask

    task automatic t_clkout();
        logic seen;
        for (int i = 0; i < 4; i++) begin
            u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL1, {3'h0, i[1], 4'h0});
            u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL2, {4'h0, i[0], 3'h0});
            seen = 1'b0;
            repeat (8) begin
                @(posedge mclk);
                #1 seen = seen | crystal_clock_out;
            end
            cmp_pin(seen, i != 3);
        end
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL1, 8'h00);
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL2, 8'h00);
    endtask

    task automatic t_alarm();
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL1, 8'hc0);
        pulse_match(1'b0);
        cmp_pin(irq_pin_a_n, 1'b0);
        pulse_match(1'b1);
        cmp_pin(irq_pin_b_n, 1'b0);
        chk_reg(rtc_pkg::ADDR_CTRL2, 8'h03);
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL2, 8'h07);
        chk_reg(rtc_pkg::ADDR_CTRL2, 8'h03);
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL2, 8'h02);
        chk_reg(rtc_pkg::ADDR_CTRL2, 8'h02);
        cmp_pin(irq_pin_a_n, 1'b1);
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL1, 8'h40);
        chk_reg(rtc_pkg::ADDR_CTRL2, 8'h00);
        pulse_match(1'b1);
        cmp_pin(irq_pin_b_n, 1'b1);
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL1, 8'h80);
        pulse_match(1'b1);
        cmp_pin(irq_pin_b_n, 1'b0);
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL2, 8'h01);
        cmp_pin(irq_pin_b_n, 1'b1);
        chk_reg(rtc_pkg::ADDR_CTRL2, 8'h00);
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL1, 8'h00);
    endtask

    task automatic t_periodic();
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL1, {5'h0, rtc_pkg::CT_LOW});
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL2, 8'h00);
        cmp_pin(irq_pin_a_n, 1'b0);
        chk_reg(rtc_pkg::ADDR_CTRL2, 8'h04);
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL1, {5'h0, rtc_pkg::CT_1HZ});
        u_rtc_host_model.wr(rtc_pkg::ADDR_SEC, 8'h00);
        cmp_pin(irq_pin_a_n, 1'b0);
        chk_reg(rtc_pkg::ADDR_CTRL2, 8'h04);
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL1, {5'h0, rtc_pkg::CT_OFF});
        chk_reg(rtc_pkg::ADDR_CTRL2, 8'h00);
    endtask

    // Last second of year 99; seconds written last to clear divider
    task automatic t_second();
        int n;
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL1, {5'h04, rtc_pkg::CT_SEC});
        for (int i = 6; i >= 0; i--) begin
            u_rtc_host_model.wr(4'(i), wv[i]);
        end
        repeat (65496) @(posedge mclk);
        chk_reg(rtc_pkg::ADDR_SEC, 8'h59);
        n = 0;
        while (irq_pin_a_n === 1'b1 && n < 100) begin
            @(posedge mclk);
            #1 n++;
        end
        cmp_pin(irq_pin_a_n, 1'b0);
        for (int i = 0; i < 7; i++) begin
            chk_reg(4'(i), ev[i]);
        end
        chk_reg(rtc_pkg::ADDR_CTRL2, 8'h04);
        u_rtc_host_model.wr(rtc_pkg::ADDR_CTRL2, 8'h00);
        cmp_pin(irq_pin_a_n, 1'b1);
    endtask

    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_clkout();
        t_alarm();
        t_periodic();
        t_second();
        stop_test();
    end
endmodule // rtc_time_calendar_tb
